// ---- logic/converter_enable_and_adc_select.sv ----
// Converter enable path, light-load auto-off, regulator source and sampler control
`timescale 1ns/1ps

// Function
// - Data-ready flag, bit 7 of sampler config two, sets when a result is stored.
// - Readback select bits 5:3 pick the presented result: limit-out, output, input.
// - Host reads stored results while another channel converts, undisturbed.
// - Conversion select bits 2:0 choose the converted channel among eight.
// - Override 0 picks regulator source automatically; 1 uses the select bit.
// - Source select bit 0: output supply at 0, input supply at 1, manual only.
// - Master enable low keeps the converter off whatever pin or override says.
// - With master enable, run needs pin or override and high impedance low.
// - Pin bypass ignores the enable pin; master enable with high impedance low requests running.
// - Soft-start select bit 5: 1.5 ms at 0, 5 ms at 1, resets to 1.
// - Light-load delay bits 3:2: off, 10 s, 20 s, 30 s.
// - After light-load shutdown stay off until disabled and re-enabled.
// - Pin polarity bit 1: active low at 0, active high at 1, resets 1.
// - Auto-off enable bit 0 gates the whole light-load shutdown function.
// - One-shot and scan-all bits choose looping or single pass, one or all.
// - Two result bytes hold upper and lower parts of the 14-bit result.
module converter_enable_and_adc_select
  import conv_ctrl_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR        = DEV_ADDR_DEFAULT,
  parameter logic [2:0]  DIE_REV         = DIE_REV_DEFAULT,
  parameter int unsigned SS_SHORT        = SS_SHORT_CYCLES,
  parameter int unsigned SS_LONG         = SS_LONG_CYCLES,
  parameter int unsigned OFF_STEP        = OFF_STEP_CYCLES
) (
  input  wire logic  mclk,
  input  wire logic  reset_n,
  input  wire logic  sclIn,
  input  wire logic  sdaIn,
  output logic       sdaOut,
  output logic       sdaOeN,
  input  wire logic  enablePin,
  input  wire logic  highImpedanceState,
  input  wire logic  lightLoad,
  input  wire logic  auxRegAutoFromInput,
  output logic       auxRegFromInput,
  output logic       converterRun,
  output logic       latchedOff,
  output logic       softStartLong,
  output logic       softStartActive,
  output conv_req_s  convReq,
  input  conv_rsp_s  convRsp
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT, SEQ_HALT} seq_e;

  typedef struct packed {
    logic [7:0]       cfg1;
    logic [6:0]       cfg2;
    logic [7:0]       regSrc;
    logic [7:0]       rsvdC;
    logic [7:0]       rsvdD;
    logic [7:0]       ctl1;
    logic             ready;
    logic [7:0][13:0] results;
    seq_e             seq;
    conv_req_s        req;
    logic             run;
    logic             latched;
    logic             auxFromIn;
    logic             ssActive;
  } top_s;

  top_s       s_q;
  top_s       s_d;
  logic [1:0] rstSync;
  logic       rstN;
  reg_wr_s    regWr;
  logic       rdStb;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  logic       ssDone;
  logic       offExpired;
  logic       request;
  logic       pinActive;
  logic       offTimerRun;
  logic [13:0] shown;
  logic [31:0] ssLimit;
  logic [31:0] offLimit;

  // Maps a readback code to the slot of the stored result
  function automatic logic [2:0] readbackSlot(input logic [2:0] code);
    case (code)
      RB_LIM_OUT: begin
        readbackSlot = SLOT_LIM_OUT;
      end
      RB_VOUT: begin
        readbackSlot = SLOT_VOUT;
      end
      RB_VIN: begin
        readbackSlot = SLOT_VIN;
      end
      default: readbackSlot = code;
    endcase
  endfunction : readbackSlot

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  serial_reg_port #(
    .DEV_ADDR (DEV_ADDR)
  ) u_port (
    .mclk   (mclk),
    .rstN   (rstN),
    .sclIn  (sclIn),
    .sdaIn  (sdaIn),
    .sdaOut (sdaOut),
    .sdaOeN (sdaOeN),
    .regWr  (regWr),
    .rdStb  (rdStb),
    .rdAddr (rdAddr),
    .rdData (rdData)
  );

  assign ssLimit = s_q.ctl1[SS_SEL_BIT] ? SS_LONG : SS_SHORT;

  interval_timer #(
    .W (32)
  ) u_soft (
    .mclk    (mclk),
    .rstN    (rstN),
    .run     (s_q.run),
    .limit   (ssLimit),
    .expired (ssDone)
  );

  assign offLimit = 32'(OFF_STEP * 32'(s_q.ctl1[OFF_DELAY_LSB +: 2]));
  assign offTimerRun = s_q.run & s_q.ctl1[OFF_LOAD_BIT] & lightLoad
                     & (s_q.ctl1[OFF_DELAY_LSB +: 2] != 2'h0);

  interval_timer #(
    .W (32)
  ) u_offload (
    .mclk    (mclk),
    .rstN    (rstN),
    .run     (offTimerRun),
    .limit   (offLimit),
    .expired (offExpired)
  );

  assign pinActive = s_q.ctl1[POLARITY_BIT] ? enablePin : ~enablePin;
  assign request = s_q.ctl1[MASTER_EN_BIT] & ~highImpedanceState
                 & (s_q.ctl1[BYPASS_BIT] | pinActive);

  assign shown = s_q.results[readbackSlot(s_q.cfg2[RB_SEL_LSB +: 3])];

  // Register readback mux
  always_comb begin
    case (rdAddr)
      RESULT_HI_OFS: begin
        rdData = shown[13:6];
      end
      RESULT_LO_OFS: begin
        rdData = {2'h0, shown[5:0]};
      end
      SAMPLER_CFG1_OFS: begin
        rdData = {s_q.cfg1[7:3], DIE_REV};
      end
      SAMPLER_CFG2_OFS: begin
        rdData = {s_q.ready, s_q.cfg2};
      end
      REG_SRC_OFS: begin
        rdData = s_q.regSrc;
      end
      RSVD_C_OFS: begin
        rdData = s_q.rsvdC;
      end
      RSVD_D_OFS: begin
        rdData = s_q.rsvdD;
      end
      CONV_CTL1_OFS: begin
        rdData = s_q.ctl1;
      end
      default:          rdData = 8'h00;
    endcase
  end

  always_comb begin
    s_d           = s_q;
    s_d.req.start = 1'b0;
    // Register writes
    if (regWr.stb) begin
      case (regWr.addr)
        SAMPLER_CFG1_OFS: begin
          s_d.cfg1 = {regWr.data[7:3], 3'h0};
        end
        SAMPLER_CFG2_OFS: begin
          s_d.cfg2 = regWr.data[6:0];
        end
        REG_SRC_OFS: begin
          s_d.regSrc = regWr.data;
        end
        RSVD_C_OFS: begin
          s_d.rsvdC = regWr.data;
        end
        RSVD_D_OFS: begin
          s_d.rsvdD = regWr.data;
        end
        CONV_CTL1_OFS: begin
          s_d.ctl1 = regWr.data;
        end
        default: ;
      endcase
    end

    // cleared by reading the low result byte; a new result wins
    if (rdStb && rdAddr == RESULT_LO_OFS) begin
      s_d.ready = 1'b0;
    end

    case (s_q.seq)
      SEQ_IDLE: begin
        if (s_q.cfg1[SAMP_EN_BIT]) begin
          s_d.req.channel = s_q.cfg1[SCAN_ALL_BIT] ? 3'h0 : s_q.cfg2[CONV_SEL_LSB +: 3];
          s_d.seq         = SEQ_START;
        end
      end
      SEQ_START: begin
        s_d.req.start = 1'b1;
        s_d.seq       = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (convRsp.done) begin
          s_d.results[s_q.req.channel] = convRsp.result;
          s_d.ready                    = 1'b1;
          if (!s_q.cfg1[SAMP_EN_BIT]) begin
            s_d.seq = SEQ_IDLE;
          end else if (s_q.cfg1[SCAN_ALL_BIT]) begin
            s_d.req.channel = s_q.req.channel + 3'h1;
            s_d.seq         = (s_q.cfg1[ONE_SHOT_BIT] && s_q.req.channel == LAST_CHANNEL)
                            ? SEQ_HALT : SEQ_START;
          end else begin
            s_d.req.channel = s_q.cfg2[CONV_SEL_LSB +: 3];
            s_d.seq         = s_q.cfg1[ONE_SHOT_BIT] ? SEQ_HALT : SEQ_START;
          end
        end
      end
      SEQ_HALT: begin
        if (!s_q.cfg1[SAMP_EN_BIT]) begin
          s_d.seq = SEQ_IDLE;
        end
      end
      default: s_d.seq = SEQ_IDLE;
    endcase

    // latch-off, released only by dropping the request
    if (!request) begin
      s_d.latched = 1'b0;
    end else if (offExpired) begin
      s_d.latched = 1'b1;
    end
    s_d.run      = request & ~s_q.latched & ~offExpired;
    s_d.ssActive = s_q.run & ~ssDone;

    s_d.auxFromIn = s_q.regSrc[SRC_MANUAL_BIT] ? s_q.regSrc[SRC_SEL_BIT]
                                               : auxRegAutoFromInput;
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s_q        <= '0;
      s_q.cfg1   <= SAMPLER_CFG1_RST;
      s_q.cfg2   <= SAMPLER_CFG2_RST[6:0];
      s_q.regSrc <= REG_SRC_RST;
      s_q.rsvdC  <= RSVD_C_RST;
      s_q.rsvdD  <= RSVD_D_RST;
      s_q.ctl1   <= CONV_CTL1_RST;
      s_q.seq    <= SEQ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign auxRegFromInput = s_q.auxFromIn;
  assign converterRun    = s_q.run;
  assign latchedOff      = s_q.latched;
  assign softStartLong   = s_q.ctl1[SS_SEL_BIT];
  assign softStartActive = s_q.ssActive;
  assign convReq         = s_q.req;

endmodule : converter_enable_and_adc_select

// ---- logic/conv_ctrl_pkg.sv ----
// Shared constants, types and register map for the converter control block
package conv_ctrl_pkg;

  // Clock rate
  localparam int unsigned MCLK_HZ  = 25_000_000;
  localparam int unsigned MCLK_MHZ = 25;

  // Soft-start ramp times and derived cycle counts
  localparam int unsigned SS_SHORT_US     = 1500;
  localparam int unsigned SS_LONG_US      = 5000;
  localparam int unsigned SS_SHORT_CYCLES = SS_SHORT_US * MCLK_MHZ;
  localparam int unsigned SS_LONG_CYCLES  = SS_LONG_US * MCLK_MHZ;

  // Light-load delay step (codes 1..3 are multiples of it)
  localparam int unsigned OFF_STEP_S      = 10;
  localparam int unsigned OFF_STEP_CYCLES = OFF_STEP_S * MCLK_HZ;

  // Serial port
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h25;
  localparam logic [2:0] DIE_REV_DEFAULT  = 3'h0; // Arbitrary revision code

  // Register offsets
  localparam logic [7:0] RESULT_HI_OFS    = 8'h07;
  localparam logic [7:0] RESULT_LO_OFS    = 8'h08;
  localparam logic [7:0] SAMPLER_CFG1_OFS = 8'h09;
  localparam logic [7:0] SAMPLER_CFG2_OFS = 8'h0a;
  localparam logic [7:0] REG_SRC_OFS      = 8'h0b;
  localparam logic [7:0] RSVD_C_OFS       = 8'h0c;
  localparam logic [7:0] RSVD_D_OFS       = 8'h0d;
  localparam logic [7:0] CONV_CTL1_OFS    = 8'h0e;

  // Reset values
  localparam logic [7:0] SAMPLER_CFG1_RST = 8'h00;
  localparam logic [7:0] SAMPLER_CFG2_RST = 8'h00;
  localparam logic [7:0] REG_SRC_RST      = 8'h80;
  localparam logic [7:0] RSVD_C_RST       = 8'h10;
  localparam logic [7:0] RSVD_D_RST       = 8'h08;
  localparam logic [7:0] CONV_CTL1_RST    = 8'ha2;

  // Field positions
  localparam int READY_BIT      = 7;
  localparam int RB_SEL_LSB     = 3;
  localparam int CONV_SEL_LSB   = 0;
  localparam int SAMP_EN_BIT    = 7;
  localparam int ONE_SHOT_BIT   = 6;
  localparam int SCAN_ALL_BIT   = 5;
  localparam int SRC_MANUAL_BIT = 1;
  localparam int SRC_SEL_BIT    = 0;
  localparam int MASTER_EN_BIT  = 7;
  localparam int BYPASS_BIT     = 6;
  localparam int SS_SEL_BIT     = 5;
  localparam int OFF_DELAY_LSB  = 2;
  localparam int POLARITY_BIT   = 1;
  localparam int OFF_LOAD_BIT   = 0;

  // Readback codes and result slots
  localparam logic [2:0] RB_LIM_OUT   = 3'h0;
  localparam logic [2:0] RB_VOUT      = 3'h1;
  localparam logic [2:0] RB_VIN       = 3'h2;
  localparam logic [2:0] SLOT_VIN     = 3'h1;
  localparam logic [2:0] SLOT_LIM_OUT = 3'h3;
  localparam logic [2:0] SLOT_VOUT    = 3'h6;
  localparam logic [2:0] LAST_CHANNEL = 3'h7;

  typedef struct packed {
    logic       start;
    logic [2:0] channel;
  } conv_req_s;

  typedef struct packed {
    logic        done;
    logic [13:0] result;
  } conv_rsp_s;

  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

endpackage : conv_ctrl_pkg

// ---- logic/interval_timer.sv ----
// Counts cycles while enabled and flags when a limit is reached
`timescale 1ns/1ps
module interval_timer
  import conv_ctrl_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         mclk,
  input  wire logic         rstN,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  output logic              expired
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         expired;
  } tmr_s;

  tmr_s s_q;
  tmr_s s_d;

  always_comb begin
    s_d = s_q;
    if (!run) begin
      s_d.count   = '0;
      s_d.expired = 1'b0;
    end else if (!s_q.expired) begin
      s_d.count = s_q.count + W'(1);
      if (s_q.count + W'(1) >= limit) begin
        s_d.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.expired;

endmodule : interval_timer

// ---- logic/serial_reg_port.sv ----
// Two-wire serial slave giving byte access to the register file
`timescale 1ns/1ps
module serial_reg_port
  import conv_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic       mclk,
  input  wire logic       rstN,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOeN,
  output reg_wr_s         regWr,
  output logic            rdStb,
  output logic [7:0]      rdAddr,
  input  wire logic [7:0] rdData
);

  typedef enum logic [3:0] {
    P_IDLE, P_ADDR, P_AACK, P_REG, P_RACK, P_WDATA, P_WACK, P_RDATA, P_MACK
  } port_e;

  typedef struct packed {
    port_e      st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic       rw;
    logic       pull;
    logic       sclPrev;
    logic       sdaPrev;
    reg_wr_s    wr;
    logic       rdStb;
    logic       zero;
  } port_s;

  port_s s_q;
  port_s s_d;
  logic  sclRise;
  logic  sclFall;

  assign sclRise = sclIn & ~s_q.sclPrev;
  assign sclFall = ~sclIn & s_q.sclPrev;

  always_comb begin
    s_d         = s_q;
    s_d.sclPrev = sclIn;
    s_d.sdaPrev = sdaIn;
    s_d.wr.stb  = 1'b0;
    s_d.rdStb   = 1'b0;
    if (s_q.sclPrev && sclIn && s_q.sdaPrev && !sdaIn) begin
      s_d.st     = P_ADDR;
      s_d.bitCnt = 4'h0;
      s_d.pull   = 1'b0;
    end else if (s_q.sclPrev && sclIn && !s_q.sdaPrev && sdaIn) begin
      s_d.st   = P_IDLE;
      s_d.pull = 1'b0;
    end else if (sclRise) begin
      case (s_q.st)
        P_ADDR, P_REG, P_WDATA: begin
          s_d.shift  = {s_q.shift[6:0], sdaIn};
          s_d.bitCnt = s_q.bitCnt + 4'h1;
        end
        P_RDATA: s_d.bitCnt = s_q.bitCnt + 4'h1;
        P_MACK: begin
          if (sdaIn) begin
            s_d.st = P_IDLE;
          end
        end
        default: ;
      endcase
    end else if (sclFall) begin
      case (s_q.st)
        P_ADDR: begin
          if (s_q.bitCnt == 4'h8) begin
            if (s_q.shift[7:1] == DEV_ADDR) begin
              s_d.rw   = s_q.shift[0];
              s_d.pull = 1'b1;
              s_d.st   = P_AACK;
            end else begin
              s_d.st = P_IDLE;
            end
          end
        end
        P_AACK, P_MACK: begin
          s_d.bitCnt = 4'h0;
          if (s_q.rw) begin
            s_d.shift = rdData;
            s_d.pull  = ~rdData[7];
            s_d.rdStb = 1'b1;
            s_d.st    = P_RDATA;
          end else begin
            s_d.pull = 1'b0;
            s_d.st   = P_REG;
          end
        end
        P_REG: begin
          if (s_q.bitCnt == 4'h8) begin
            s_d.ptr  = s_q.shift;
            s_d.pull = 1'b1;
            s_d.st   = P_RACK;
          end
        end
        P_WDATA: begin
          if (s_q.bitCnt == 4'h8) begin
            s_d.wr.stb  = 1'b1;
            s_d.wr.addr = s_q.ptr;
            s_d.wr.data = s_q.shift;
            s_d.pull    = 1'b1;
            s_d.st      = P_WACK;
          end
        end
        P_RACK, P_WACK: begin
          if (s_q.st == P_WACK) begin
            s_d.ptr = s_q.ptr + 8'h01;
          end
          s_d.pull   = 1'b0;
          s_d.bitCnt = 4'h0;
          s_d.st     = P_WDATA;
        end
        P_RDATA: begin
          if (s_q.bitCnt == 4'h8) begin
            s_d.pull = 1'b0;
            s_d.ptr  = s_q.ptr + 8'h01;
            s_d.st   = P_MACK;
          end else begin
            s_d.shift = {s_q.shift[6:0], 1'b0};
            s_d.pull  = ~s_q.shift[6];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s_q         <= '0;
      s_q.st      <= P_IDLE;
      s_q.sclPrev <= 1'b1;
      s_q.sdaPrev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sdaOut = s_q.zero;
  assign sdaOeN = ~s_q.pull;
  assign regWr  = s_q.wr;
  assign rdStb  = s_q.rdStb;
  assign rdAddr = s_q.ptr;

endmodule : serial_reg_port

// ---- test/converter_enable_and_adc_select_assertions.sv ----
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module converter_enable_and_adc_select_assertions
  import conv_ctrl_pkg::*;
#(
  parameter int unsigned SS_LONG = SS_LONG_CYCLES
) (
  input wire logic      mclk,
  input wire logic      reset_n,
  input wire logic      highImpedanceState,
  input wire logic      lightLoad,
  input wire logic      converterRun,
  input wire logic      latchedOff,
  input wire logic      softStartActive,
  input wire conv_req_s convReq,
  input wire conv_rsp_s convRsp
);
  logic        busyQ;
  int unsigned ssCntQ;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busyQ  <= 1'b0;
      ssCntQ <= 0;
    end else begin
      busyQ  <= convReq.start | (busyQ & ~convRsp.done);
      ssCntQ <= softStartActive ? ssCntQ + 1 : 0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_hiz_stops_run: assert property (highImpedanceState [*3] |-> !converterRun)
    else $error("converter runs in high impedance state");
  a_latch_stops_run: assert property (latchedOff |=> !converterRun)
    else $error("converter runs while latched off");
  a_latch_needs_load: assert property ($rose(latchedOff) |-> $past(lightLoad, 2) && $past(lightLoad, 8))
    else $error("latch-off without sustained light load");
  a_latch_needs_run: assert property ($rose(latchedOff) |-> $past(converterRun))
    else $error("latch-off while converter idle");
  a_ss_follows_run: assert property ($rose(converterRun) |=> softStartActive)
    else $error("soft start missing after run");
  a_ss_bounded: assert property (ssCntQ <= SS_LONG + 1)
    else $error("soft start lasts too long");
  a_start_pulse: assert property (convReq.start |=> !convReq.start)
    else $error("conversion start longer than one cycle");
  a_chan_set_first: assert property (convReq.start |-> $stable(convReq.channel))
    else $error("channel changed at start");
  a_conv_undisturbed: assert property (busyQ |-> $stable(convReq.channel) && !convReq.start)
    else $error("conversion disturbed before done");
endmodule : converter_enable_and_adc_select_assertions

bind converter_enable_and_adc_select converter_enable_and_adc_select_assertions #(
  .SS_LONG(SS_LONG)
) i_converter_enable_and_adc_select_assertions (
  .mclk(mclk), .reset_n(reset_n), .highImpedanceState(highImpedanceState),
  .lightLoad(lightLoad), .converterRun(converterRun), .latchedOff(latchedOff),
  .softStartActive(softStartActive), .convReq(convReq), .convRsp(convRsp)
);

// ---- test/i2c_host_model.sv ----
// Host-side two-wire bus model with open-drain data
`timescale 1ns/1ps
module i2c_host_model
  import conv_ctrl_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaLow
);
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic phase(input logic low, input int a, input int b);
    sdaLow = low;
    tick(a);
    scl = 1'b1;
    tick(b);
  endtask : phase
  task automatic put_bit(input logic b);
    phase(~b, 4, 6);
    scl = 1'b0;
    tick(4);
  endtask : put_bit
  task automatic get_bit(output logic b);
    phase(1'b0, 4, 3);
    b = sdaWire;
    tick(3);
    scl = 1'b0;
    tick(4);
  endtask : get_bit
  task automatic start_cond;
    phase(1'b0, 4, 6);
    sdaLow = 1'b1;
    tick(6);
    scl = 1'b0;
    tick(4);
  endtask : start_cond
  task automatic send_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
  endtask : send_byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start_cond();
    send_byte({DEV_ADDR_DEFAULT, 1'b0});
    send_byte(a);
    send_byte(d);
    phase(1'b1, 4, 6);
    sdaLow = 1'b0;
    tick(6);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start_cond();
    send_byte({DEV_ADDR_DEFAULT, 1'b0});
    send_byte(a);
    start_cond();
    send_byte({DEV_ADDR_DEFAULT, 1'b1});
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    phase(1'b1, 4, 6);
    sdaLow = 1'b0;
    tick(6);
  endtask : rd
endmodule : i2c_host_model

// ---- test/converter_enable_and_adc_select_bench.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module converter_enable_and_adc_select_bench
  import conv_ctrl_pkg::*;
;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic       enablePin = 1'b0;
  logic       highImpedanceState = 1'b0;
  logic       lightLoad = 1'b0;
  logic       auxRegAutoFromInput = 1'b0;
  logic       sdaOut, sdaOeN, scl, sdaLow, sdaWire;
  logic       auxRegFromInput, converterRun, latchedOff, softStartLong, softStartActive;
  conv_req_s  convReq;
  conv_rsp_s  convRsp = '0;
  int         n_mismatch = 0;
  int         checked = 0;
  int         cyc = 0;
  int         rspDly = 10;
  logic [2:0] chSeen[$];

  assign sdaWire = !(sdaLow || (!sdaOeN && !sdaOut));

  converter_enable_and_adc_select #(
    .SS_SHORT(20), .SS_LONG(50), .OFF_STEP(100)
  ) i_converter_enable_and_adc_select (
    .mclk(mclk), .reset_n(reset_n), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .enablePin(enablePin), .highImpedanceState(highImpedanceState),
    .lightLoad(lightLoad), .auxRegAutoFromInput(auxRegAutoFromInput),
    .auxRegFromInput(auxRegFromInput), .converterRun(converterRun),
    .latchedOff(latchedOff), .softStartLong(softStartLong),
    .softStartActive(softStartActive), .convReq(convReq), .convRsp(convRsp)
  );
  i2c_host_model i_i2c_host_model (.mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));

  initial forever #20 mclk = ~mclk;

  function automatic logic [13:0] res_of(input logic [2:0] c);
    return {c, 8'h5a, c};
  endfunction : res_of
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_i2c_host_model.wr(a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_i2c_host_model.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask : rdc
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Conversion responder answering each start after rspDly cycles
  initial forever begin
    @(negedge mclk);
    if (convReq.start === 1'b1) begin
      chSeen.push_back(convReq.channel);
      repeat (rspDly) @(negedge mclk);
      convRsp = '{done: 1'b1, result: res_of(convReq.channel)};
      @(negedge mclk);
      convRsp = '0;
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic t_reset;
    rdc(8'h0a, 8'h00);
    rdc(8'h09, 8'h00);
    rdc(8'h0b, 8'h80);
    rdc(8'h0c, 8'h10);
    rdc(8'h0d, 8'h08);
    rdc(8'h0e, 8'ha2);
    rdc(8'h20, 8'h00);
    chk("softStartLong", 8'h01, {7'h0, softStartLong});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_regsrc;
    for (int i = 0; i < 8; i++) begin
      auxRegAutoFromInput = i[2];
      wr(8'h0b, 8'h80 | 8'(i[1:0]));
      tick(3);
      chk("auxRegFromInput", {7'h0, i[1] ? i[0] : i[2]}, {7'h0, auxRegFromInput});
    end
    $display("t_regsrc done");
  endtask : t_regsrc
  task automatic t_enable;
    logic [10:0] tb[8] = '{{8'ha2, 3'b101}, {8'ha2, 3'b000}, {8'ha0, 3'b001},
      {8'ha0, 3'b100}, {8'ha2, 3'b110}, {8'h22, 3'b100}, {8'he2, 3'b001}, {8'h62, 3'b100}};
    foreach (tb[i]) begin
      enablePin = tb[i][2];
      highImpedanceState = tb[i][1];
      wr(8'h0e, tb[i][10:3]);
      tick(6);
      chk("converterRun", {7'h0, tb[i][0]}, {7'h0, converterRun});
    end
    highImpedanceState = 1'b0;
    $display("t_enable done");
  endtask : t_enable
  task automatic t_softstart;
    int n;
    for (int k = 0; k < 2; k++) begin
      enablePin = 1'b0;
      wr(8'h0e, k ? 8'ha2 : 8'h82);
      chk("softStartLong", {7'h0, k[0]}, {7'h0, softStartLong});
      enablePin = 1'b1;
      n = 0;
      repeat (200) begin
        tick(1);
        if (softStartActive === 1'b1) n++;
      end
      n = n - (k ? 50 : 20);
      chk("softStartLenOk", 8'h01, {7'h0, n >= -1 && n <= 1});
    end
    $display("t_softstart done");
  endtask : t_softstart
  task automatic t_lightload;
    int n;
    logic [7:0] v[2] = '{8'ha6, 8'ha3};
    for (int c = 1; c < 4; c++) begin
      lightLoad = 1'b0;
      wr(8'h0e, 8'ha3 | 8'(c << 2));
      lightLoad = 1'b1;
      tick(40);
      lightLoad = 1'b0;
      tick(1);
      lightLoad = 1'b1;
      n = 0;
      while (latchedOff !== 1'b1 && n < 400) begin
        tick(1);
        n++;
      end
      chk("offDelayOk", 8'h01, {7'h0, n >= c*100-2 && n <= c*100+3});
      lightLoad = 1'b0;
      tick(20);
      chk("runLatched", 8'h00, {7'h0, converterRun});
      enablePin = 1'b0;
      tick(4);
      enablePin = 1'b1;
      tick(6);
      chk("runRestart", 8'h01, {7'h0, converterRun});
    end
    foreach (v[i]) begin
      wr(8'h0e, v[i]);
      lightLoad = 1'b1;
      tick(350);
      chk("noLatch", 8'h01, {7'h0, converterRun & ~latchedOff});
      lightLoad = 1'b0;
    end
    $display("t_lightload done");
  endtask : t_lightload
  task automatic t_sampler;
    logic [13:0] r;
    logic [2:0] slot[3] = '{3'h3, 3'h6, 3'h1};
    wr(8'h0a, 8'h05);
    wr(8'h09, 8'hc0);
    tick(40);
    chk("oneShotChannel", 8'h05, {5'h0, chSeen[$]});
    rdc(8'h0a, 8'h85);
    rdc(8'h08, 8'h00);
    rdc(8'h0a, 8'h05);
    wr(8'h09, 8'h00);
    wr(8'h0a, 8'h00);
    chSeen.delete();
    wr(8'h09, 8'he0);
    tick(200);
    chk("scanCount", 8'h08, 8'(chSeen.size()));
    foreach (chSeen[i]) chk("scanChannel", 8'(i), {5'h0, chSeen[i]});
    rdc(8'h0a, 8'h80);
    for (int k = 0; k < 3; k++) begin
      r = res_of(slot[k]);
      wr(8'h0a, 8'(k << 3));
      rdc(8'h07, r[13:6]);
      rdc(8'h08, {2'b00, r[5:0]});
    end
    r = res_of(3'h5);
    wr(8'h0a, 8'h28);
    rdc(8'h07, r[13:6]);
    wr(8'h09, 8'h00);
    chSeen.delete();
    wr(8'h09, 8'ha0);
    tick(150);
    chk("loopScan", 8'h01, {5'h0, chSeen[9]});
    wr(8'h09, 8'h00);
    rspDly = 2000;
    wr(8'h09, 8'h00);
    wr(8'h0a, 8'h17);
    wr(8'h09, 8'h80);
    r = res_of(3'h1);
    rdc(8'h07, r[13:6]);
    chk("convChannel", 8'h07, {5'h0, convReq.channel});
    wr(8'h09, 8'h00);
    tick(2000);
    $display("t_sampler done");
  endtask : t_sampler

  initial begin
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    tick(6);
    t_reset();
    t_regsrc();
    t_enable();
    t_softstart();
    t_lightload();
    t_sampler();
    finish_test();
  end
endmodule : converter_enable_and_adc_select_bench
